// ==== hw/tofsum_pkg.sv ====
package tofsum_pkg;

  // clock and turn-off timing base
  localparam int unsigned TOFSUM_CLK_HZ        = 10_000_000;  // core clock rate
  localparam int unsigned TOFSUM_CYC_PER_MS    = TOFSUM_CLK_HZ / 1000;  // cycles per ms
  localparam int unsigned TOFSUM_TICKS_PER_MS  = 1024;  // timing tick is 1/1024 ms
  localparam int          TOFSUM_TICK_SHIFT    = 10;  // log2 of ticks per ms
  localparam logic [13:0] TOFSUM_ACC_INC       = 14'(TOFSUM_TICKS_PER_MS);  // added each cycle
  localparam logic [13:0] TOFSUM_ACC_MOD       = 14'(TOFSUM_CYC_PER_MS);  // wrap of the accumulator
  localparam int unsigned TOFSUM_FALL_MIN_US   = 500;  // shortest real fall time, us
  localparam logic [31:0] TOFSUM_FALL_MIN_TICKS =
    32'((TOFSUM_FALL_MIN_US * TOFSUM_TICKS_PER_MS + 999) / 1000);  // same in ticks
  localparam logic [3:0]  TOFSUM_RAMP_MAX_PHASES = 4'h2;  // ramp only up to two phases
  localparam int          TOFSUM_STEP_SHIFT    = 8;  // ramp level has 256 steps
  localparam int          TOFSUM_SAT_SHIFT     = 21;  // largest shift before saturation
  localparam int          TOFSUM_PAGES         = 2;  // number of output pages

  // command codes
  localparam logic [7:0]  TOFSUM_CMD_CLEAR     = 8'h03;
  localparam logic [7:0]  TOFSUM_CMD_DELAY     = 8'h64;
  localparam logic [7:0]  TOFSUM_CMD_FALL      = 8'h65;
  localparam logic [7:0]  TOFSUM_CMD_SUM_BYTE  = 8'h78;
  localparam logic [7:0]  TOFSUM_CMD_SUM_WORD  = 8'h79;
  localparam logic [7:0]  TOFSUM_CMD_COMM      = 8'h7e;

  // reset values
  localparam logic [15:0] TOFSUM_LIN_RESET     = 16'hca80;  // 5 ms in linear-11
  localparam logic [15:0] TOFSUM_SUM_RESET     = 16'h0000;
  localparam logic [7:0]  TOFSUM_COMM_RESET    = 8'h00;
  localparam logic [7:0]  TOFSUM_LEVEL_FULL    = 8'hff;

  // linear-11 field layout
  localparam int TOFSUM_EXP_MSB = 15;
  localparam int TOFSUM_EXP_LSB = 11;
  localparam int TOFSUM_MAN_MSB = 10;

  // summary bit positions
  localparam int TOFSUM_SB_OUTPUT_VOLTAGE  = 15;
  localparam int TOFSUM_SB_OUTPUT_CURRENT_EVENT_FLAG  = 14;
  localparam int TOFSUM_SB_INPUT = 13;
  localparam int TOFSUM_SB_VEND  = 12;
  localparam int TOFSUM_SB_PGN   = 11;
  localparam int TOFSUM_SB_OTHER = 9;
  localparam int TOFSUM_SB_BUSY  = 7;
  localparam int TOFSUM_SB_OFF   = 6;
  localparam int TOFSUM_SB_OV    = 5;
  localparam int TOFSUM_SB_OC    = 4;
  localparam int TOFSUM_SB_UV    = 3;
  localparam int TOFSUM_SB_TEMP  = 2;
  localparam int TOFSUM_SB_CML   = 1;
  localparam int TOFSUM_SB_NONE  = 0;

  // communication status bit positions
  localparam int TOFSUM_CM_BADCMD  = 7;
  localparam int TOFSUM_CM_BADDATA = 6;
  localparam int TOFSUM_CM_PEC     = 5;

  // turn-off sequencer states
  typedef enum logic [1:0] {
    TOFSUM_ST_OFF,
    TOFSUM_ST_ON,
    TOFSUM_ST_DELAY,
    TOFSUM_ST_FALL
  } tofsum_seq_t;

  // decoded command from the bus protocol engine
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        page;
    logic [7:0]  code;
    logic [1:0]  nbytes;
    logic [15:0] wdata;
    logic        pec_err;
  } tofsum_req_t;

  // answer to the protocol engine
  typedef struct packed {
    logic        valid;
    logic        ack;
    logic [1:0]  nbytes;
    logic [15:0] data;
  } tofsum_rsp_t;

  // live condition flags of one page
  typedef struct packed {
    logic busy;
    logic output_overvoltage_flag;
    logic output_overcurrent_flag;
    logic input_undervoltage_flag;
    logic temperature_event;
    logic comm_logic_memory_flag;
    logic output_voltage_event;
    logic output_current_event_flag;
    logic input_voltage_event;
    logic vendor_event_flag;
    logic power_good;
    logic detail_status_any;
  } tofsum_flags_t;

  // state of one page
  typedef struct packed {
    tofsum_seq_t seq;
    logic [15:0] delay_time;
    logic [15:0] fall_time;
    logic [31:0] cnt;
    logic [23:0] step_len;
    logic [23:0] step_cnt;
    logic [7:0]  level;
    logic        stage_en;
    logic [2:0]  sync;
    logic        en;
    logic [15:0] summary;
  } tofsum_page_t;

endpackage

// ==== hw/tofsum_top.sv ====
`timescale 1ns/1ps

module tofsum_top
  import tofsum_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire tofsum_req_t                 req,
  output tofsum_rsp_t                      rsp,
  input  wire logic [TOFSUM_PAGES-1:0]     enable_pin,
  input  wire logic [3:0]                  phase_count,
  input  wire tofsum_flags_t [TOFSUM_PAGES-1:0] flags,
  output logic [TOFSUM_PAGES-1:0]          stage_en,
  output logic [TOFSUM_PAGES-1:0]          ramping,
  output logic [TOFSUM_PAGES-1:0][7:0]     ramp_level,
  output logic [7:0]                       comm_status
);

  // whole module state
  typedef struct packed {
    tofsum_page_t [TOFSUM_PAGES-1:0] pg;
    logic [13:0]                     acc;
    logic                            tick;
    logic [7:0]                      comm;
    tofsum_rsp_t                     rsp;
  } tofsum_state_t;

  tofsum_state_t s_q;  // registered state
  tofsum_state_t s_d;  // next state

  // linear-11 setting to ticks of 1/1024 ms, saturating
  function automatic logic [31:0] tofsum_lin_ticks(input logic [15:0] v);
    logic signed [4:0]  e;
    logic signed [10:0] m;
    int                 sh;
    logic [31:0]        r;
    e  = signed'(v[TOFSUM_EXP_MSB:TOFSUM_EXP_LSB]);
    m  = signed'(v[TOFSUM_MAN_MSB:0]);
    sh = int'(e) + TOFSUM_TICK_SHIFT;
    r  = 32'h0;
    if (m < 0) begin
      r = 32'h0;  // negative time means none
    end else if (sh > TOFSUM_SAT_SHIFT) begin
      r = 32'hffffffff;  // beyond range, hold at max
    end else if (sh >= 0) begin
      r = {21'h0, m} << sh;
    end else begin
      r = {21'h0, m} >> (-sh);
    end
    return r;
  endfunction

  // command code is one of the readable ones
  function automatic logic tofsum_known(input logic [7:0] c);
    return (c == TOFSUM_CMD_DELAY) || (c == TOFSUM_CMD_FALL) ||
           (c == TOFSUM_CMD_SUM_BYTE) || (c == TOFSUM_CMD_SUM_WORD) ||
           (c == TOFSUM_CMD_COMM);
  endfunction

  // next-state logic
  always_comb begin
    logic [31:0]   fall_ticks;
    logic          wr_ok;
    logic          comm_clr;
    logic [7:0]    comm_set;
    logic [15:0]   sum;
    tofsum_flags_t f;
    fall_ticks = 32'h0;
    wr_ok      = 1'b0;
    comm_clr   = 1'b0;
    comm_set   = 8'h00;
    sum        = TOFSUM_SUM_RESET;
    f          = '0;
    s_d        = s_q;

    // fractional tick: 1024 ticks per 10000 cycles on average
    if (s_q.acc + TOFSUM_ACC_INC >= TOFSUM_ACC_MOD) begin
      s_d.acc  = 14'(s_q.acc + TOFSUM_ACC_INC - TOFSUM_ACC_MOD);
      s_d.tick = 1'b1;
    end else begin
      s_d.acc  = 14'(s_q.acc + TOFSUM_ACC_INC);
      s_d.tick = 1'b0;
    end

    // response pulses for one cycle only
    s_d.rsp = '0;

    // bus request handling
    if (req.valid) begin
      s_d.rsp.valid = 1'b1;
      if (req.pec_err) begin
        comm_set[TOFSUM_CM_PEC] = 1'b1;
      end else if (req.write) begin
        if (req.code == TOFSUM_CMD_CLEAR) begin
          comm_clr      = 1'b1;  // clear comm flags
          s_d.rsp.ack   = 1'b1;
        end else if (req.code == TOFSUM_CMD_DELAY || req.code == TOFSUM_CMD_FALL) begin
          wr_ok = (req.nbytes == 2'd2);
          if (!wr_ok) begin
            comm_set[TOFSUM_CM_BADDATA] = 1'b1;
          end
          s_d.rsp.ack = wr_ok;
        end else begin
          // read-only or unknown codes refuse writes
          comm_set[TOFSUM_CM_BADCMD] = 1'b1;
        end
      end else begin
        // reads
        s_d.rsp.ack    = tofsum_known(req.code);
        s_d.rsp.nbytes = 2'd1;
        case (req.code)
          TOFSUM_CMD_DELAY: begin
            s_d.rsp.data   = s_q.pg[req.page].delay_time;
            s_d.rsp.nbytes = 2'd2;
          end
          TOFSUM_CMD_FALL: begin
            s_d.rsp.data   = s_q.pg[req.page].fall_time;
            s_d.rsp.nbytes = 2'd2;
          end
          TOFSUM_CMD_SUM_BYTE: begin
            s_d.rsp.data = {8'h00, s_q.pg[req.page].summary[7:0]};
          end
          TOFSUM_CMD_SUM_WORD: begin
            s_d.rsp.data   = s_q.pg[req.page].summary;
            s_d.rsp.nbytes = 2'd2;
          end
          TOFSUM_CMD_COMM: begin
            s_d.rsp.data = {8'h00, s_q.comm};
          end
          default: begin
            s_d.rsp.nbytes = 2'd0;
            comm_set[TOFSUM_CM_BADCMD] = 1'b1;
          end
        endcase
      end
    end

    // comm status: a new event wins over a clear
    s_d.comm = ((comm_clr ? 8'h00 : s_q.comm) | comm_set);

    // per-page sequencer and summary
    for (int i = 0; i < TOFSUM_PAGES; i++) begin
      // enable pin: three flops, change taken when second and third agree
      s_d.pg[i].sync = {s_q.pg[i].sync[1:0], enable_pin[i]};
      if (s_q.pg[i].sync[2] == s_q.pg[i].sync[1]) begin
        s_d.pg[i].en = s_q.pg[i].sync[2];
      end

      // setting writes for the addressed page
      if (req.valid && !req.pec_err && req.write && wr_ok && req.page == 1'(i)) begin
        if (req.code == TOFSUM_CMD_DELAY) begin
          s_d.pg[i].delay_time = req.wdata;
        end else begin
          s_d.pg[i].fall_time = req.wdata;
        end
      end

      fall_ticks = tofsum_lin_ticks(s_q.pg[i].fall_time);

      case (s_q.pg[i].seq)
        TOFSUM_ST_OFF: begin
          // output unpowered until enabled
          if (s_q.pg[i].en) begin
            s_d.pg[i].seq      = TOFSUM_ST_ON;
            s_d.pg[i].stage_en = 1'b1;
            s_d.pg[i].level    = TOFSUM_LEVEL_FULL;
          end
        end
        TOFSUM_ST_ON: begin
          // disable starts the turn-off delay
          if (!s_q.pg[i].en) begin
            s_d.pg[i].seq = TOFSUM_ST_DELAY;
            s_d.pg[i].cnt = tofsum_lin_ticks(s_q.pg[i].delay_time);
          end
        end
        TOFSUM_ST_DELAY: begin
          if (s_q.pg[i].en) begin
            s_d.pg[i].seq = TOFSUM_ST_ON;  // re-enabled, abort turn-off
          end else if (s_q.pg[i].cnt == 32'h0) begin
            if (phase_count > TOFSUM_RAMP_MAX_PHASES ||
                fall_ticks < TOFSUM_FALL_MIN_TICKS) begin
              // power stage off at once
              s_d.pg[i].seq      = TOFSUM_ST_OFF;
              s_d.pg[i].stage_en = 1'b0;
              s_d.pg[i].level    = 8'h00;
            end else begin
              s_d.pg[i].seq      = TOFSUM_ST_FALL;
              s_d.pg[i].cnt      = fall_ticks;
              // one level step per step_len ticks so the level hits zero in time
              s_d.pg[i].step_len = fall_ticks[31:TOFSUM_STEP_SHIFT];
              s_d.pg[i].step_cnt = fall_ticks[31:TOFSUM_STEP_SHIFT] - 24'h1;
            end
          end else if (s_q.tick) begin
            s_d.pg[i].cnt = s_q.pg[i].cnt - 32'h1;
          end
        end
        TOFSUM_ST_FALL: begin
          if (s_q.pg[i].en) begin
            s_d.pg[i].seq   = TOFSUM_ST_ON;  // re-enabled mid-ramp
            s_d.pg[i].level = TOFSUM_LEVEL_FULL;
          end else if (s_q.pg[i].cnt == 32'h0) begin
            s_d.pg[i].seq      = TOFSUM_ST_OFF;  // ramp done
            s_d.pg[i].stage_en = 1'b0;
            s_d.pg[i].level    = 8'h00;
          end else if (s_q.tick) begin
            s_d.pg[i].cnt = s_q.pg[i].cnt - 32'h1;
            if (s_q.pg[i].step_cnt == 24'h0) begin
              s_d.pg[i].step_cnt = s_q.pg[i].step_len - 24'h1;
              if (s_q.pg[i].level != 8'h00) begin
                s_d.pg[i].level = s_q.pg[i].level - 8'h1;
              end
            end else begin
              s_d.pg[i].step_cnt = s_q.pg[i].step_cnt - 24'h1;
            end
          end
        end
        default: begin
          s_d.pg[i].seq = TOFSUM_ST_OFF;
        end
      endcase

      // summary follows the live flags, the stage enable and the comm status
      f = flags[i];
      sum[TOFSUM_SB_OUTPUT_VOLTAGE]  = f.output_voltage_event;
      sum[TOFSUM_SB_OUTPUT_CURRENT_EVENT_FLAG]  = f.output_current_event_flag;
      sum[TOFSUM_SB_INPUT] = f.input_voltage_event;
      sum[TOFSUM_SB_VEND]  = f.vendor_event_flag;
      sum[TOFSUM_SB_PGN]   = !f.power_good;
      sum[TOFSUM_SB_OTHER] = f.detail_status_any || (s_q.comm != 8'h00);
      sum[TOFSUM_SB_BUSY]  = f.busy;
      sum[TOFSUM_SB_OFF]   = !s_d.pg[i].stage_en;
      sum[TOFSUM_SB_OV]    = f.output_overvoltage_flag;
      sum[TOFSUM_SB_OC]    = f.output_overcurrent_flag;
      sum[TOFSUM_SB_UV]    = f.input_undervoltage_flag;
      sum[TOFSUM_SB_TEMP]  = f.temperature_event;
      sum[TOFSUM_SB_CML]   = f.comm_logic_memory_flag || (s_q.comm != 8'h00);
      // other fault: a source in bits 15 to 12 with nothing in bits 7 to 1
      sum[TOFSUM_SB_NONE]  = (|sum[15:12]) && !(|sum[7:1]);
      s_d.pg[i].summary    = sum;
    end
  end

  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      for (int i = 0; i < TOFSUM_PAGES; i++) begin
        s_q.pg[i].seq        <= TOFSUM_ST_OFF;
        s_q.pg[i].delay_time <= TOFSUM_LIN_RESET;
        s_q.pg[i].fall_time  <= TOFSUM_LIN_RESET;
        s_q.pg[i].summary    <= TOFSUM_SUM_RESET;
      end
      s_q.comm <= TOFSUM_COMM_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  always_comb begin
    rsp         = s_q.rsp;
    comm_status = s_q.comm;
    for (int i = 0; i < TOFSUM_PAGES; i++) begin
      stage_en[i]   = s_q.pg[i].stage_en;
      ramping[i]    = (s_q.pg[i].seq == TOFSUM_ST_FALL);
      ramp_level[i] = s_q.pg[i].level;
    end
  end

endmodule

// ==== tb/tofsum_chk_sva.sv ====
`timescale 1ns/1ps

// watches command answers and the turn-off outputs at the top ports
module tofsum_chk
  import tofsum_pkg::*;
(
  input wire logic                            clk,
  input wire logic                            sys_rst,
  input wire tofsum_req_t                     req,
  input wire tofsum_rsp_t                     rsp,
  input wire logic [TOFSUM_PAGES-1:0]         enable_pin,
  input wire logic [3:0]                      phase_count,
  input wire tofsum_flags_t [TOFSUM_PAGES-1:0] flags,
  input wire logic [TOFSUM_PAGES-1:0]         stage_en,
  input wire logic [TOFSUM_PAGES-1:0]         ramping,
  input wire logic [TOFSUM_PAGES-1:0][7:0]    ramp_level,
  input wire logic [7:0]                      comm_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic rd_ok;  // clean read this cycle
  logic wr_ok;  // clean write this cycle
  assign rd_ok = req.valid && !req.write && !req.pec_err;
  assign wr_ok = req.valid && req.write && !req.pec_err;

  property p_byte;
    rd_ok && req.code == TOFSUM_CMD_SUM_BYTE |=> rsp.ack && rsp.nbytes == 2'd1 && rsp.data[15:8] == 8'h00;
  endproperty
  a_byte: assert property (p_byte) else $error("summary byte read not one byte");
  property p_word;
    rd_ok && req.code == TOFSUM_CMD_SUM_WORD |=> rsp.ack && rsp.nbytes == 2'd2;
  endproperty
  a_word: assert property (p_word) else $error("summary word read not two bytes");
  property p_unused;
    rd_ok && req.code == TOFSUM_CMD_SUM_WORD |=> !rsp.data[10] && !rsp.data[8];
  endproperty
  a_unused: assert property (p_unused) else $error("unused summary bit set");
  property p_ro;
    wr_ok && (req.code == TOFSUM_CMD_SUM_BYTE || req.code == TOFSUM_CMD_SUM_WORD)
      |=> !rsp.ack && comm_status[TOFSUM_CM_BADCMD];
  endproperty
  a_ro: assert property (p_ro) else $error("summary write accepted");
  property p_len;
    wr_ok && (req.code == TOFSUM_CMD_DELAY || req.code == TOFSUM_CMD_FALL) && req.nbytes != 2'd2
      |=> !rsp.ack && comm_status[TOFSUM_CM_BADDATA];
  endproperty
  a_len: assert property (p_len) else $error("short setting write accepted");
  property p_pec;
    req.valid && req.pec_err |=> !rsp.ack && comm_status[TOFSUM_CM_PEC];
  endproperty
  a_pec: assert property (p_pec) else $error("packet error not flagged");
  property p_fast;
    phase_count > TOFSUM_RAMP_MAX_PHASES |-> ramping == '0;
  endproperty
  a_fast: assert property (p_fast) else $error("ramp in multi-phase mode");
  property p_hold;
    ramping[1] && ramp_level[1] != 8'h00 |=> stage_en[1];
  endproperty
  a_hold: assert property (p_hold) else $error("stage off before ramp end");
  property p_step;
    ramping[1] ##1 ramping[1] |-> ramp_level[1] <= $past(ramp_level[1]);
  endproperty
  a_step: assert property (p_step) else $error("ramp level rose");
endmodule

bind tofsum_top tofsum_chk u_chk (.clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp),
  .enable_pin(enable_pin), .phase_count(phase_count), .flags(flags), .stage_en(stage_en),
  .ramping(ramping), .ramp_level(ramp_level), .comm_status(comm_status));

// ==== tb/tofsum_host.sv ====
`timescale 1ns/1ps

// host side: one decoded command at a time
module tofsum_host
  import tofsum_pkg::*;
(
  input wire logic        clk,
  output tofsum_req_t     req,
  input wire tofsum_rsp_t rsp
);
  initial req = '0;

  // raise at falling edge, taken at next rising edge, answer read after it
  task automatic xfer(input logic w, input logic pg, input logic [7:0] cd,
                      input logic [1:0] nb, input logic [15:0] wd, input logic pe,
                      output tofsum_rsp_t r);
    @(negedge clk);
    req = '{valid: 1'b1, write: w, page: pg, code: cd, nbytes: nb, wdata: wd, pec_err: pe};
    @(negedge clk);
    r = rsp;
    // released fields flip so stale values never pass for live ones
    req = tofsum_req_t'({1'b0, ~req[$bits(tofsum_req_t)-2:0]});
  endtask
endmodule

// ==== tb/tofsum_bench.sv ====
`timescale 1ns/1ps

// register reads, refusals, summary bits and turn-off sequences
module tofsum_bench;
  import tofsum_pkg::*;
  logic                             clk = 1'b0;
  logic                             sys_rst = 1'b1;
  tofsum_req_t                      req;
  tofsum_rsp_t                      rsp;
  logic [TOFSUM_PAGES-1:0]          enable_pin = '0;
  logic [3:0]                       phase_count = 4'h2;
  tofsum_flags_t [TOFSUM_PAGES-1:0] flags = {2{tofsum_flags_t'(12'h002)}};
  logic [TOFSUM_PAGES-1:0]          stage_en;
  logic [TOFSUM_PAGES-1:0]          ramping;
  logic [TOFSUM_PAGES-1:0][7:0]     ramp_level;
  logic [7:0]                       comm_status;
  tofsum_rsp_t                      r;
  int                               errors = 0;
  int                               n_checks = 0;
  int                               n;
  // word for each flag flipped alone, busy first, page powered
  logic [15:0] sum_exp [12] = '{16'h0080, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0002,
                                16'h8001, 16'h4001, 16'h2001, 16'h1001, 16'h0800, 16'h0200};

  always #50 clk = ~clk;

  tofsum_top dut (.clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp), .enable_pin(enable_pin),
    .phase_count(phase_count), .flags(flags), .stage_en(stage_en), .ramping(ramping),
    .ramp_level(ramp_level), .comm_status(comm_status));
  tofsum_host u_host (.clk(clk), .req(req), .rsp(rsp));

  // compare and count
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // disable page 1 and time the delay, then the ramp or the cut
  task automatic toff(input logic [3:0] ph, input logic [15:0] fall, input logic rmp);
    u_host.xfer(1'b1, 1'b1, TOFSUM_CMD_DELAY, 2'd2, 16'hb004, 1'b0, r);
    u_host.xfer(1'b1, 1'b1, TOFSUM_CMD_FALL, 2'd2, fall, 1'b0, r);
    u_host.xfer(1'b0, 1'b1, TOFSUM_CMD_FALL, 2'd0, 16'h0, 1'b0, r);
    chk(r.data, fall);
    phase_count = ph;
    enable_pin[1] = 1'b1;
    repeat (10) @(negedge clk);
    enable_pin[1] = 1'b0;
    n = 0;
    while (stage_en[1] && !ramping[1] && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n >= 34 && n <= 50), 16'h1);
    chk(16'(ramping[1]), 16'(rmp));
    n = 0;
    while (stage_en[1] && n < 12000) begin
      @(negedge clk);
      n++;
    end
    chk(16'(ramp_level[1]), 16'h0);
    u_host.xfer(1'b0, 1'b1, TOFSUM_CMD_SUM_WORD, 2'd0, 16'h0, 1'b0, r);
    chk(r.data & 16'h0040, 16'h0040);
  endtask

  // main sequence
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    u_host.xfer(1'b0, 1'b0, TOFSUM_CMD_DELAY, 2'd0, 16'h0, 1'b0, r);
    chk(r.data, TOFSUM_LIN_RESET);
    u_host.xfer(1'b0, 1'b1, TOFSUM_CMD_FALL, 2'd0, 16'h0, 1'b0, r);
    chk(r.data, TOFSUM_LIN_RESET);
    u_host.xfer(1'b0, 1'b0, TOFSUM_CMD_SUM_WORD, 2'd0, 16'h0, 1'b0, r);
    chk(r.data, 16'h0040);
    u_host.xfer(1'b0, 1'b0, TOFSUM_CMD_SUM_BYTE, 2'd0, 16'h0, 1'b0, r);
    chk(r.data, 16'h0040);
    // refusals: read-only write, short write, packet error, unknown read
    u_host.xfer(1'b1, 1'b0, TOFSUM_CMD_SUM_WORD, 2'd2, 16'hffff, 1'b0, r);
    chk(16'(r.ack), 16'h0);
    u_host.xfer(1'b1, 1'b0, TOFSUM_CMD_DELAY, 2'd1, 16'h0001, 1'b0, r);
    u_host.xfer(1'b0, 1'b0, TOFSUM_CMD_DELAY, 2'd0, 16'h0, 1'b1, r);
    u_host.xfer(1'b0, 1'b0, 8'h20, 2'd0, 16'h0, 1'b0, r);
    chk({r.ack, r.nbytes}, 16'h0);
    chk(16'(comm_status), 16'h00e0);
    u_host.xfer(1'b0, 1'b0, TOFSUM_CMD_DELAY, 2'd0, 16'h0, 1'b0, r);
    chk(r.data, TOFSUM_LIN_RESET);
    u_host.xfer(1'b1, 1'b0, TOFSUM_CMD_CLEAR, 2'd0, 16'h0, 1'b0, r);
    chk(16'(comm_status), 16'h0000);
    enable_pin[1] = 1'b1;
    repeat (10) @(negedge clk);
    for (int i = 0; i < 12; i++) begin
      flags[1] = tofsum_flags_t'(12'h002 ^ (12'h800 >> i));
      repeat (2) @(negedge clk);
      u_host.xfer(1'b0, 1'b1, TOFSUM_CMD_SUM_WORD, 2'd0, 16'h0, 1'b0, r);
      chk(r.data, sum_exp[i]);
      u_host.xfer(1'b0, 1'b1, TOFSUM_CMD_SUM_BYTE, 2'd0, 16'h0, 1'b0, r);
      chk(r.data, {8'h00, sum_exp[i][7:0]});
    end
    flags[1] = tofsum_flags_t'(12'h002);
    toff(4'h2, 16'h0001, 1'b1);
    toff(4'h4, 16'h0001, 1'b0);
    toff(4'h1, 16'hb1ff, 1'b0);
    finish_test();
  end

  // watchdog well past the expected run
  initial begin
    #6_000_000;
    errors++;
    finish_test();
  end
endmodule
